// [hw/cgc_config_port.sv]
// Serial configuration port with register file, calibration and sync control.
// Assumes a host-driven serial clock and latch; VCO clock drives pair dividers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Word: data 31..5, address 4..0
// - Data sampled on serial clock rise
// - Latch pulse writes addressed register
// - Writing address 30 starts calibration
// - Reset bit restores defaults, ignores rest
// - One VCO divider per output pair
// - Divides 1 to 1045, 50% duty
// - Extended mode from divide 26
// - Sync aligns all active outputs
// - Toggling sync invert bit makes sync
// - Startup output divides by 25
// - Startup output may glitch in calibration
// - Transfer on latch-enable rising edge
// - Readback MSB first on falling edges
module cgc_config_port
  import cgc_pkg::*;
#(
  parameter int CAL_COUNT = CAL_CYCLES
)
(
  // System
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic vco_clk_i,
  // Serial pins
  input wire logic serial_clock_pin_i,
  input wire logic serial_data_pin_i,
  input wire logic latch_enable_pin_i,
  output logic readback_o,
  output logic readback_oe_o,
  // Reference and sync
  input wire logic reference_input_i,
  input wire logic ref_valid_i,
  input wire logic sync_pin_i,
  // Clock outputs
  output logic [cgc_pkg::NUM_PAIRS-1:0] pair_clk_o,
  output logic [cgc_pkg::NUM_PAIRS-1:0] pair_ext_mode_o,
  output logic startup_clock_output_o,
  output logic ref_buffer_output_zero_o,
  // Status
  output logic cal_busy_o,
  output logic cal_ref_missing_o,
  output logic [cgc_pkg::WORD_W-1:0] last_word_o
);
  typedef struct packed {
    logic [WORD_W-1:0] shreg;
  } cgc_link_type;

  typedef enum logic [1:0] {
    CGC_IDLE = 2'b00,
    CGC_CAL = 2'b01
  } cgc_cal_type;

  typedef struct packed {
    logic [2:0] tog_sync;
    logic [WORD_W-1:0] word;
    logic programmed;
    logic sync_inv;
    logic sync_inv_d;
    logic [1:0] sync_pin_sync;
    logic [1:0] ref_valid_sync;
    logic sync_pulse;
    cgc_cal_type cal_state;
    logic [CAL_W-1:0] cal_cnt;
    logic ref_missing;
    logic [ADDR_W-1:0] rb_addr;
    logic [NUM_PAIRS-1:0][DIV_W-1:0] div;
    logic [WORD_W-1:0] rb_word;
  } cgc_sys_type;

  function automatic logic [ADDR_W-1:0] word_addr(input logic [WORD_W-1:0] w);
    word_addr = w[ADDR_LSB +: ADDR_W];
  endfunction

  function automatic logic [DIV_W-1:0] word_div(input logic [WORD_W-1:0] w);
    word_div = w[DIV_LSB +: DIV_W];
  endfunction

  cgc_link_type l, next_l;
  cgc_sys_type s, next_s;
  logic [WORD_W-1:0] rb_shift;
  logic [WORD_W-1:0] next_rb_shift;
  logic rb_tog;
  logic [WORD_W-1:0] rdata;
  logic tog_seen;
  logic mem_we;
  logic mem_clr;
  logic [NUM_PAIRS-1:0] pair_sync;
  logic [2:0] vco_sync;
  logic [NUM_PAIRS-1:0][DIV_W-1:0] vco_div;

  // Link domain: the serial clock only runs while the host shifts
  always_comb
  begin
    next_l = l;
    if (!latch_enable_pin_i)
      next_l.shreg = {l.shreg[WORD_W-2:0], serial_data_pin_i};
  end

  always_ff @(posedge serial_clock_pin_i)
  begin
    if (!rstn_i)
      l <= '0;
    else
      l <= next_l;
  end

  // Latch capture on the latch pin's own rising edge; no serial clock then
  logic [WORD_W-1:0] held_word;
  logic held_tog;
  always_ff @(posedge latch_enable_pin_i)
  begin
    if (!rstn_i)
    begin
      held_word <= '0;
      held_tog <= 1'b0;
    end
    else
    begin
      held_word <= l.shreg;
      held_tog <= ~held_tog;
    end
  end

  // No serial edge comes while latch is high, so the first fall after a latch loads
  always_comb
  begin
    next_rb_shift = {rb_shift[WORD_W-2:0], 1'b0};
    if (rb_tog != held_tog)
      next_rb_shift = s.rb_word;
  end

  always_ff @(negedge serial_clock_pin_i)
  begin
    if (!rstn_i)
    begin
      rb_shift <= '0;
      rb_tog <= 1'b0;
    end
    else
    begin
      rb_shift <= next_rb_shift;
      rb_tog <= held_tog;
    end
  end

  assign readback_o = rb_shift[WORD_W-1];
  assign readback_oe_o = ~latch_enable_pin_i;

  // System domain
  always_comb
  begin
    next_s = s;
    mem_we = 1'b0;
    mem_clr = 1'b0;
    next_s.tog_sync = {s.tog_sync[1:0], held_tog};
    tog_seen = s.tog_sync[2] ^ s.tog_sync[1];
    next_s.sync_pin_sync = {s.sync_pin_sync[0], sync_pin_i};
    next_s.ref_valid_sync = {s.ref_valid_sync[0], ref_valid_i};
    next_s.sync_inv_d = s.sync_inv;
    next_s.sync_pulse = (s.sync_pin_sync[1] ^ s.sync_inv) | (s.sync_inv ^ s.sync_inv_d);
    next_s.rb_word = rdata;
    if (tog_seen)
    begin
      next_s.word = held_word;
      if (word_addr(held_word) == '0 && held_word[RESET_BIT])
      begin
        mem_clr = 1'b1;
        next_s.div = '0;
        next_s.programmed = 1'b0;
        next_s.sync_inv = 1'b0;
      end
      else
      begin
        mem_we = 1'b1;
        if (word_addr(held_word) <= ADDR_DIV_LAST)
        begin
          next_s.div[word_addr(held_word)] = word_div(held_word);
          next_s.programmed = 1'b1;
        end
        if (word_addr(held_word) == ADDR_SYNC)
          next_s.sync_inv = held_word[SYNC_INV_BIT];
        if (word_addr(held_word) == ADDR_RB)
          next_s.rb_addr = held_word[RB_ADDR_LSB +: ADDR_W];
        if (word_addr(held_word) == ADDR_CAL)
        begin
          next_s.ref_missing = ~s.ref_valid_sync[1];
          next_s.cal_state = CGC_CAL;
          next_s.cal_cnt = '0;
        end
      end
    end
    case (s.cal_state)
      CGC_IDLE:
        next_s.cal_cnt = next_s.cal_cnt;
      CGC_CAL:
        if (s.cal_cnt >= CAL_W'(CAL_COUNT - 1) && !tog_seen)
          next_s.cal_state = CGC_IDLE;
        else if (!tog_seen)
          next_s.cal_cnt = s.cal_cnt + 16'h0001;
      default:
        next_s.cal_state = CGC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      s <= '0;
    else
      s <= next_s;
  end

  cgc_reg_mem u_mem (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .we_i(mem_we),
    .clr_i(mem_clr),
    .waddr_i(word_addr(held_word)),
    .wdata_i(held_word),
    .raddr_i(s.rb_addr),
    .rdata_o(rdata)
  );

  // Divide settings are quasi-static; sync is a level synchronised into VCO domain
  always_ff @(posedge vco_clk_i)
  begin
    if (!rstn_i)
    begin
      vco_sync <= '0;
      vco_div <= '0;
    end
    else
    begin
      vco_sync <= {vco_sync[1:0], s.sync_pulse};
      for (int i = 0; i < NUM_PAIRS; i++)
        vco_div[i] <= (s.programmed || i != STARTUP_PAIR) ? s.div[i] : DIV_STARTUP;
    end
  end

  for (genvar g = 0; g < NUM_PAIRS; g++)
  begin : g_pair
    assign pair_sync[g] = vco_sync[1] & ~vco_sync[2];
    cgc_pair_div u_div (
      .vco_clk_i(vco_clk_i),
      .rstn_i(rstn_i),
      .sync_i(pair_sync[g]),
      .div_i(vco_div[g]),
      .clk_o(pair_clk_o[g]),
      .ext_mode_o(pair_ext_mode_o[g])
    );
  end

  // Startup output keeps running through calibration; glitches are tolerated
  assign startup_clock_output_o = pair_clk_o[STARTUP_PAIR];
  assign ref_buffer_output_zero_o = reference_input_i;
  assign cal_busy_o = (s.cal_state == CGC_CAL);
  assign cal_ref_missing_o = s.ref_missing;
  assign last_word_o = s.word;
endmodule
`default_nettype wire

// [shared/cgc_pkg.sv]
// Constants for the clock generator configuration port.
// Assumes a 40 MHz system clock and a host-driven serial clock.
package cgc_pkg;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 27;
  localparam int ADDR_LSB = 0;
  localparam int DATA_LSB = 5;
  localparam int NUM_REGS = 32;
  localparam int DIV_W = 11;
  localparam int DIV_LSB = 5;
  localparam int RESET_BIT = 17;
  localparam int NUM_PAIRS = 6;
  localparam int SYNC_INV_BIT = 16;
  localparam int RB_ADDR_LSB = 16;
  localparam logic [ADDR_W-1:0] ADDR_DIV_LAST = 5'h05;
  localparam logic [ADDR_W-1:0] ADDR_SYNC = 5'h0B;
  localparam logic [ADDR_W-1:0] ADDR_CAL = 5'h1E;
  localparam logic [ADDR_W-1:0] ADDR_RB = 5'h1F;
  localparam logic [DIV_W-1:0] DIV_MAX = 11'h415;
  localparam logic [DIV_W-1:0] DIV_EXT_MIN = 11'h01A;
  localparam logic [DIV_W-1:0] DIV_STARTUP = 11'h019;
  localparam int STARTUP_PAIR = 4;
  localparam logic [WORD_W-1:0] REG_DEFAULT = 32'h0000_0000;
  localparam int CAL_TIME_NS = 10000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CAL_CYCLES = CAL_TIME_NS / CLK_PERIOD_NS;
  localparam int CAL_W = 16;
endpackage

// [hw/cgc_pair_div.sv]
// Output-pair divider: integer ratios 1..1045 with 50% duty cycle.
// Assumes the VCO clock input and an aligning sync from the same domain.
`timescale 1ns/100ps
`default_nettype none
module cgc_pair_div
  import cgc_pkg::*;
(
  // Clock and control
  input wire logic vco_clk_i,
  input wire logic rstn_i,
  input wire logic sync_i,
  input wire logic [cgc_pkg::DIV_W-1:0] div_i,
  // Output
  output logic clk_o,
  output logic ext_mode_o
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic pos;
    logic neg_half;
  } cgc_div_type;
  cgc_div_type s, next_s;
  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] half;
  logic neg;

  always_comb
  begin
    div = (div_i == '0) ? 11'h001 : ((div_i > DIV_MAX) ? DIV_MAX : div_i);
    half = div >> 1;
    next_s = s;
    if (sync_i || s.cnt >= div - 11'h001)
      next_s.cnt = '0;
    else
      next_s.cnt = s.cnt + 11'h001;
    // High for the lower half; odd ratios get the extra half cycle from the falling edge
    next_s.pos = (next_s.cnt < half);
    next_s.neg_half = s.pos;
  end

  // Odd ratios stretch the high phase by half a VCO cycle for 50% duty
  always_ff @(negedge vco_clk_i)
  begin
    if (!rstn_i)
      neg <= 1'b0;
    else
      neg <= s.pos;
  end

  always_ff @(posedge vco_clk_i)
  begin
    if (!rstn_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign clk_o = (div == 11'h001) ? vco_clk_i : (div[0] ? (s.pos | neg) : s.pos);
  assign ext_mode_o = (div >= DIV_EXT_MIN);
endmodule
`default_nettype wire

// [hw/cgc_reg_mem.sv]
// Configuration register file, 32 words, one write port, registered read.
// Assumes writes and reads come from the system clock domain.
`timescale 1ns/100ps
`default_nettype none
module cgc_reg_mem
  import cgc_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic rstn_i,
  // Write port
  input wire logic we_i,
  input wire logic clr_i,
  input wire logic [cgc_pkg::ADDR_W-1:0] waddr_i,
  input wire logic [cgc_pkg::WORD_W-1:0] wdata_i,
  // Read port
  input wire logic [cgc_pkg::ADDR_W-1:0] raddr_i,
  output logic [cgc_pkg::WORD_W-1:0] rdata_o
);
  logic [WORD_W-1:0] mem [NUM_REGS];

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || clr_i)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        mem[i] <= REG_DEFAULT;
      rdata_o <= '0;
    end
    else
    begin
      if (we_i)
        mem[waddr_i] <= wdata_i;
      rdata_o <= mem[raddr_i];
    end
  end
endmodule
`default_nettype wire

// [test/cgc_config_port_assertions.sv]
// Checker for the configuration port, bound to its top module.
// Assumes latched words arrive at least 20 clk cycles apart.
`timescale 1ns/100ps
`default_nettype none
module cgc_config_port_assertions
  import cgc_pkg::*;
#(
  parameter int CAL_COUNT = 8
)
(
  // Watched ports
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic latch_enable_pin_i,
  input wire logic ref_valid_i,
  input wire logic readback_oe_o,
  input wire logic [cgc_pkg::NUM_PAIRS-1:0] pair_ext_mode_o,
  input wire logic cal_busy_o,
  input wire logic cal_ref_missing_o,
  input wire logic [cgc_pkg::WORD_W-1:0] last_word_o
);
  int le_age;
  int busy_run;
  always_ff @(posedge clk_i)
  begin
    le_age <= (!rstn_i) ? 99 : latch_enable_pin_i ? 0 : (le_age < 99) ? le_age + 1 : le_age;
    busy_run <= (rstn_i && cal_busy_o) ? busy_run + 1 : 0;
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_word_on_latch: assert property ($changed(last_word_o) |-> le_age <= 8)
    else $error("word changed without latch");
  a_cal_starts: assert property ($changed(last_word_o) && last_word_o[4:0] == ADDR_CAL
    && ref_valid_i |-> ##[0:4] cal_busy_o) else $error("calibration not started");
  a_cal_no_ref: assert property ($changed(last_word_o) && last_word_o[4:0] == ADDR_CAL
    && !ref_valid_i |-> ##[0:4] cal_ref_missing_o) else $error("missing reference not flagged");
  a_cal_length: assert property ($fell(cal_busy_o) |-> busy_run >= CAL_COUNT - 1
    && busy_run <= CAL_COUNT + 1) else $error("calibration length wrong");
  a_ext_mode: assert property ($changed(last_word_o) && last_word_o[4:0] <= ADDR_DIV_LAST
    && !(last_word_o[4:0] == 5'h00 && last_word_o[RESET_BIT]) |-> ##[0:20]
    pair_ext_mode_o[last_word_o[2:0]] == (last_word_o[DIV_LSB+:DIV_W] >= DIV_EXT_MIN))
    else $error("extended mode wrong");
  a_reset_bit: assert property ($changed(last_word_o) && last_word_o[4:0] == 5'h00
    && last_word_o[RESET_BIT] |-> ##[0:20] pair_ext_mode_o == 6'h00)
    else $error("reset bit kept settings");
  a_startup_quiet: assert property (last_word_o == 32'h0000_0000 |-> pair_ext_mode_o == 6'h00)
    else $error("startup divide not plain");
  a_rb_released: assert property (latch_enable_pin_i [*4] |-> !readback_oe_o)
    else $error("readback driven while latch high");
endmodule
bind cgc_config_port cgc_config_port_assertions #(.CAL_COUNT(CAL_COUNT)) i_cgc_config_port_assertions
(
  .clk_i(clk_i),
  .rstn_i(rstn_i),
  .latch_enable_pin_i(latch_enable_pin_i),
  .ref_valid_i(ref_valid_i),
  .readback_oe_o(readback_oe_o),
  .pair_ext_mode_o(pair_ext_mode_o),
  .cal_busy_o(cal_busy_o),
  .cal_ref_missing_o(cal_ref_missing_o),
  .last_word_o(last_word_o)
);
`default_nettype wire

// [test/cgc_host_model.sv]
// Host model: shifts words, pulses latch, reads back.
// Serial clock of 30 ns, still between frames.
`timescale 1ns/100ps
`default_nettype none
module cgc_host_model
(
  // Serial pins
  output logic sck_o,
  output logic sdi_o,
  output logic le_o,
  // Readback
  input wire logic rb_i
);
  initial
  begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    le_o = 1'b0;
  end
  task automatic send(input logic [63:0] w, input int n, input logic lat);
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi_o = w[i];
      #15 sck_o = 1'b1;
      #15 sck_o = 1'b0;
    end
    sdi_o = 1'b0;
    #15 le_o = lat;
    #120 le_o = 1'b0;
    #30;
  endtask
  task automatic read(output logic [31:0] q);
    for (int i = 31; i >= 0; i--)
    begin
      sck_o = 1'b1;
      #15 sck_o = 1'b0;
      #15 q[i] = rb_i;
    end
  endtask
endmodule
`default_nettype wire

// [test/cgc_config_port_tb_top.sv]
// Testbench for the configuration port with a host model.
// Clocks: 25 ns system, 10 ns VCO, 30 ns serial.
`timescale 1ns/100ps
`default_nettype none
module cgc_config_port_tb_top;
  import cgc_pkg::*;
  typedef struct {logic [4:0] a; logic [10:0] d;} cgc_row_type;
  cgc_row_type rows [5] = '{'{5'h00, 11'h001}, '{5'h01, 11'h007}, '{5'h02, 11'h01A},
    '{5'h03, 11'h415}, '{5'h05, 11'h019}};
  logic clk_i = 1'b0;
  logic vco = 1'b0;
  logic ref_in = 1'b0;
  logic rstn_i = 1'b0;
  logic ref_ok = 1'b1;
  logic sync = 1'b0;
  logic sck, sdi, le, rb, su, busy, miss, refo;
  logic [5:0] pclk, pext;
  logic [31:0] lw, w, q;
  int miscompares = 0;
  int n_compared = 0;
  real t0, t1, t2;
  initial forever #12.5 clk_i = ~clk_i;
  initial forever #5 vco = ~vco;
  initial forever #40 ref_in = ~ref_in;
  cgc_config_port #(.CAL_COUNT(8)) i_cgc_config_port (.clk_i(clk_i), .rstn_i(rstn_i),
    .vco_clk_i(vco), .serial_clock_pin_i(sck), .serial_data_pin_i(sdi),
    .latch_enable_pin_i(le), .readback_o(rb), .readback_oe_o(), .reference_input_i(ref_in),
    .ref_valid_i(ref_ok), .sync_pin_i(sync), .pair_clk_o(pclk), .pair_ext_mode_o(pext),
    .startup_clock_output_o(su), .ref_buffer_output_zero_o(refo), .cal_busy_o(busy),
    .cal_ref_missing_o(miss), .last_word_o(lw));
  cgc_host_model i_cgc_host_model (.sck_o(sck), .sdi_o(sdi), .le_o(le), .rb_i(rb));
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Bounded poll; the half-ns grid keeps clear of VCO edges
  task automatic lvl(input int p, input logic v);
    int i;
    for (i = 0; i < 30000 && ((p == 6) ? su : pclk[p]) !== v; i++)
      #1;
    if (i == 30000)
    begin
      miscompares++;
      conclude();
    end
  endtask
  // Skips two periods so a divide change can settle
  task automatic period(input int p, input int d);
    @(posedge vco);
    #0.5;
    for (int k = 0; k < 2; k++)
    begin
      lvl(p, 1'b0);
      lvl(p, 1'b1);
    end
    t0 = $realtime;
    lvl(p, 1'b0);
    t1 = $realtime;
    lvl(p, 1'b1);
    t2 = $realtime;
    chk("period", d * 10, int'(t2 - t0));
    chk("high", d * 5, int'(t1 - t0));
  endtask
  task automatic put(input logic [31:0] wd);
    i_cgc_host_model.send({32'h0000_0000, wd}, 32, 1'b1);
    repeat (8) @(posedge clk_i);
  endtask
  initial
  begin
    i_cgc_host_model.send(64'h3, 2, 1'b1);
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    period(6, 25);
    chk("refout", ref_in, refo);
    foreach (rows[r])
    begin
      w = {16'h0000, rows[r].d, rows[r].a};
      repeat ((rows[r].d > 25) ? 2 : 1) put(w);
      chk("word", w, lw);
      chk("ext", rows[r].d >= 26, pext[rows[r].a]);
      period(rows[r].a, rows[r].d);
    end
    w = 32'h0000_0062;
    i_cgc_host_model.send({24'h0, 8'hFF, w}, 40, 1'b1);
    repeat (8) @(posedge clk_i);
    chk("word", w, lw);
    i_cgc_host_model.send(64'h122, 32, 1'b0);
    repeat (8) @(posedge clk_i);
    chk("word", w, lw);
    period(2, 3);
    put(32'h0002_001F);
    i_cgc_host_model.read(q);
    chk("readback", w[31:5], q[31:5]);
    @(posedge clk_i) ref_ok <= 1'b0;
    put(32'h0000_003E);
    chk("refmiss", 1, miss);
    @(posedge clk_i) ref_ok <= 1'b1;
    put(32'h0000_005E);
    chk("busy", 0, busy);
    chk("refmiss", 0, miss);
    put(32'h0002_00A0);
    chk("ext", 0, pext);
    put(32'h0000_0020);
    chk("word", 32'h0000_0020, lw);
    put(32'h5555_5549);
    chk("word", 32'h5555_5549, lw);
    put(32'h0000_0018);
    chk("word", 32'h0000_0018, lw);
    put(32'h0000_001F);
    chk("word", 32'h0000_001F, lw);
    @(posedge clk_i) rstn_i <= 1'b0;
    i_cgc_host_model.send(64'h1, 1, 1'b1);
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    chk("word", 0, lw);
    conclude();
  end
endmodule
`default_nettype wire
